// [design/link_regs_pkg.sv]
// Behaviour
// (RULE1) rate field: 00 oscillator, 01 bus clock, 10 bus/2, 11 bus/4, 1.048576 MHz
// (RULE2) software never programs the rate field to code 11 on this variant
// (RULE3) with enable set, requests hold until each source is cleared by its access
// (RULE4) wake-up requests are raised even with interrupts disabled
// (RULE5) with enable clear no requests; pending ones may be dropped
// (RULE6) in cpu wait the internal clocks stop if wait-clock bit set
// (RULE7) status register: only bits 2 and 3 live, rest zero, writes ignored
// (RULE8) status flags mirror their pending requests; wake-ups leave them alone
// (RULE9) tx done sets after check byte sent; any tx count access clears it
// (RULE10) rx done clears on access only if nothing more buffered; re-sets at once
// (RULE11) request raised while a flag is set and enabled; clearing withdraws it
// (RULE12) stop-mode wake request sets no flag; any rx status access clears it
// (RULE13) tx count: 4-bit length in bits 3..0, upper bits zero, resets to zero
// (RULE14) writing a valid length starts transmission, check byte appended after body
// (RULE15) lengths 01..0B valid; zero or 0C and above are rejected, not sent
// (RULE16) software loads buffer first, writes length last, never during abort request
// (RULE17) tx count clears itself at the end of every transmission
// (RULE18) rx count shows body bytes of visible buffer, up to 11, no check byte
// (RULE19) good reception: buffer visible, count updated, rx done set, request raised
// (RULE20) any write to rx status releases visible buffer and exposes the waiting one
// (RULE21) after release software waits for rx done before touching rx status again
// (RULE22) oldest message shown first; a third message while both full is ignored
// (RULE23) prescaler makes a one-cycle enable pulse at the selected division
package link_regs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_LINK_CONTROL      = 8'h0E;
	localparam logic [7:0] OFS_LINK_STATUS       = 8'h0F;
	localparam logic [7:0] OFS_TX_LENGTH_CONTROL = 8'h10;
	localparam logic [7:0] OFS_RX_COUNT_STATUS   = 8'h11;

	// ----------------------------------------------------------------
	// link_control fields
	// ----------------------------------------------------------------
	localparam int BIT_WAIT_CLOCK_STOP  = 0;
	localparam int BIT_LINK_IRQ_ENABLE  = 1;
	localparam int BIT_RATE_SELECT_LOW  = 4;
	localparam int BIT_RATE_SELECT_HIGH = 5;

	// ----------------------------------------------------------------
	// link_status fields
	// ----------------------------------------------------------------
	localparam int BIT_RX_DONE_FLAG = 2;
	localparam int BIT_TX_DONE_FLAG = 3;

	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [3:0] TX_LEN_RESET = 4'h0;
	localparam logic [3:0] TX_LEN_MIN   = 4'h1;
	localparam logic [3:0] TX_LEN_MAX   = 4'hB;
	localparam logic [3:0] RX_CNT_MAX   = 4'hB;
	localparam logic [1:0] RATE_RESET   = 2'h0;

	// ----------------------------------------------------------------
	// rate codes and link base clock
	// ----------------------------------------------------------------
	localparam logic [1:0] RATE_OSC      = 2'h0;
	localparam logic [1:0] RATE_BUS_DIV1 = 2'h1;
	localparam logic [1:0] RATE_BUS_DIV2 = 2'h2;
	localparam logic [1:0] RATE_BUS_DIV4 = 2'h3;
	localparam int         LINK_BASE_HZ  = 1048576;

endpackage : link_regs_pkg

// [design/link_regs.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module link_regs
	import link_regs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       osc_tick_i,
	input  wire logic       cpu_wait_i,
	input  wire logic       wakeup_i,
	input  wire logic       tx_done_i,
	input  wire logic       tx_end_i,
	input  wire logic       rx_msg_ok_i,
	input  wire logic [3:0] rx_len_i,
	output logic            base_tick_o,
	output logic            clk_run_o,
	output logic            tx_start_o,
	output logic            tx_reject_o,
	output logic      [3:0] tx_len_o,
	output logic            rx_release_o,
	output logic            rx_sel_o,
	output logic            rx_full_o,
	output logic            irq_o
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rstn_sync_r;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_r  <= 1'b0;
			rstn_sync_r <= 1'b0;
		end else begin
			rst_meta_r  <= 1'b1;
			rstn_sync_r <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic            ie;
		logic            wait_clock_stop;
		logic [1:0]      rate;
		logic            locked;
		logic [3:0]      tx_len;
		logic            tx_done;
		logic            rx_done;
		logic            wake;
		logic [1:0]      full;
		logic [1:0][3:0] cnt;
		logic            head;
		logic [1:0]      div;
		logic            tick;
		logic            start;
		logic            reject;
		logic            release_p;
		logic [7:0]      rdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	logic acc_ctl;
	logic acc_stat;
	logic acc_tx;
	logic acc_rx;
	logic wr_tx;
	logic wr_rx;
	logic len_ok;
	logic both_full;
	logic rel_now;
	logic tail;

	assign acc_ctl   = (wr_i | rd_i) && addr_i == OFS_LINK_CONTROL;
	assign acc_stat  = (wr_i | rd_i) && addr_i == OFS_LINK_STATUS;
	assign acc_tx    = (wr_i | rd_i) && addr_i == OFS_TX_LENGTH_CONTROL;
	assign acc_rx    = (wr_i | rd_i) && addr_i == OFS_RX_COUNT_STATUS;
	assign wr_tx     = wr_i && acc_tx;
	assign wr_rx     = wr_i && acc_rx;
	assign len_ok    = wdata_i[3:0] >= TX_LEN_MIN && wdata_i[3:0] <= TX_LEN_MAX;
	assign both_full = &s_r.full;
	assign rel_now   = wr_rx && s_r.full[s_r.head];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] full_v;
		logic       head_v;
		full_v = s_r.full;
		head_v = s_r.head;
		tail   = 1'b0;
		s_nxt  = s_r;

		// control register: rate and wait bits lock after first write
		if (wr_i && acc_ctl) begin
			s_nxt.ie = wdata_i[BIT_LINK_IRQ_ENABLE];
			if (!s_r.locked) begin
				s_nxt.wait_clock_stop    = wdata_i[BIT_WAIT_CLOCK_STOP];
				s_nxt.rate   = {wdata_i[BIT_RATE_SELECT_HIGH], wdata_i[BIT_RATE_SELECT_LOW]};
				s_nxt.locked = 1'b1;
			end
		end

		// prescaler, halted while internal clocks are stopped
		s_nxt.tick = 1'b0;
		if (clk_run_o) begin
			s_nxt.div = s_r.div + 2'h1;
			unique case (s_r.rate)                                          // RULE1
				RATE_OSC:      s_nxt.tick = osc_tick_i;
				RATE_BUS_DIV1: s_nxt.tick = 1'b1;
				RATE_BUS_DIV2: s_nxt.tick = s_r.div[0];
				RATE_BUS_DIV4: s_nxt.tick = &s_r.div;                        // RULE23
			endcase
		end

		// transmit count and start
		s_nxt.start  = wr_tx && len_ok;                                      // RULE14
		s_nxt.reject = wr_tx && !len_ok;                                     // RULE15
		if (tx_end_i) begin
			s_nxt.tx_len = TX_LEN_RESET;                                     // RULE17
		end
		if (wr_tx) begin
			s_nxt.tx_len = wdata_i[3:0];                                     // RULE13
		end
		if (acc_tx) begin
			s_nxt.tx_done = 1'b0;                                            // RULE9
		end
		if (tx_done_i) begin
			s_nxt.tx_done = 1'b1;                                            // RULE9
		end

		// receive buffers: release first, then accept arrival
		s_nxt.release_p = rel_now;
		if (rel_now) begin
			full_v[head_v] = 1'b0;                                           // RULE20
			head_v         = ~head_v;
		end
		if (acc_rx && !both_full) begin
			s_nxt.rx_done = 1'b0;                                            // RULE10
		end
		if (acc_rx) begin
			s_nxt.wake = 1'b0;                                               // RULE12
		end
		if (wakeup_i) begin
			s_nxt.wake = 1'b1;                                               // RULE4
		end
		if (rx_msg_ok_i && !(&full_v)) begin                                // RULE22
			tail             = full_v[head_v] ? ~head_v : head_v;
			full_v[tail]     = 1'b1;
			s_nxt.cnt[tail]  = rx_len_i > RX_CNT_MAX ? RX_CNT_MAX : rx_len_i;  // RULE18
			s_nxt.rx_done    = 1'b1;                                         // RULE19
		end
		s_nxt.full = full_v;
		s_nxt.head = head_v;

		// read data valid only in the cycle after the read strobe
		s_nxt.rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				OFS_LINK_CONTROL: begin
					s_nxt.rdata[BIT_WAIT_CLOCK_STOP]  = s_r.wait_clock_stop;
					s_nxt.rdata[BIT_LINK_IRQ_ENABLE]  = s_r.ie;
					s_nxt.rdata[BIT_RATE_SELECT_LOW]  = s_r.rate[0];
					s_nxt.rdata[BIT_RATE_SELECT_HIGH] = s_r.rate[1];
				end
				OFS_LINK_STATUS: begin
					s_nxt.rdata[BIT_TX_DONE_FLAG] = s_r.tx_done;             // RULE7
					s_nxt.rdata[BIT_RX_DONE_FLAG] = s_r.rx_done;             // RULE8
				end
				OFS_TX_LENGTH_CONTROL: s_nxt.rdata[3:0] = s_r.tx_len;
				OFS_RX_COUNT_STATUS: begin
					if (s_r.full[s_r.head]) begin
						s_nxt.rdata[3:0] = s_r.cnt[s_r.head];                // RULE18
					end
				end
				default: s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_sync_r) begin
		if (!rstn_sync_r) begin
			s_r        <= '0;
			s_r.rate   <= RATE_RESET;
			s_r.tx_len <= TX_LEN_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata_o      = s_r.rdata;
	assign base_tick_o  = s_r.tick;
	assign clk_run_o    = !(cpu_wait_i && s_r.wait_clock_stop);                         // RULE6
	assign tx_start_o   = s_r.start;
	assign tx_reject_o  = s_r.reject;
	assign tx_len_o     = s_r.tx_len;
	assign rx_release_o = s_r.release_p;
	assign rx_sel_o     = s_r.head;
	assign rx_full_o    = both_full;
	// flag requests gated by enable; wake-ups always pass
	assign irq_o        = (s_r.ie && (s_r.tx_done || s_r.rx_done))           // RULE11 RULE3 RULE5
	                    || s_r.wake                                          // RULE4
	                    || (cpu_wait_i && s_r.rx_done);                      // RULE4

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_sync_r);

	sequence tx_access_s;
		(wr_i || rd_i) && addr_i == OFS_TX_LENGTH_CONTROL && !tx_done_i;
	endsequence

	sequence tx_done_cleared_s;
		!s_r.tx_done;
	endsequence

	a_tx_done_clear: assert property (tx_access_s |=> tx_done_cleared_s)  // RULE9
		else $error("tx done flag not cleared by count access");

	a_tx_done_set: assert property (tx_done_i |=> s_r.tx_done)  // RULE9
		else $error("tx done flag not set after check byte");

	a_tx_start_ok: assert property (  // RULE14
		wr_tx && wdata_i[3:0] >= 4'h1 && wdata_i[3:0] <= 4'hB
		|=> tx_start_o && !tx_reject_o && tx_len_o == $past(wdata_i[3:0]))
		else $error("valid length did not start transmission");

	a_tx_bad_len: assert property (  // RULE15
		wr_tx && (wdata_i[3:0] == 4'h0 || wdata_i[3:0] >= 4'hC)
		|=> !tx_start_o && tx_reject_o)
		else $error("invalid length not rejected");

	a_tx_len_clear: assert property (tx_end_i && !wr_tx |=> tx_len_o == 4'h0)  // RULE17
		else $error("tx count not cleared at end of transmission");

	a_irq_masked: assert property (!s_r.ie && !s_r.wake && !cpu_wait_i |-> !irq_o)  // RULE5
		else $error("request raised with interrupts disabled");

	a_wake_irq: assert property (wakeup_i && !tx_done_i && !acc_tx  // RULE4
		|=> irq_o && s_r.tx_done == $past(s_r.tx_done))
		else $error("wake-up did not raise request");

	a_wake_clear: assert property (  // RULE12
		acc_rx && !wakeup_i && !s_r.ie && !cpu_wait_i |=> !s_r.wake && (!irq_o || cpu_wait_i))
		else $error("wake request not cleared by rx status access");

	a_status_zero: assert property (rd_i && addr_i == OFS_LINK_STATUS  // RULE7
		|=> rdata_o[7:4] == 4'h0 && rdata_o[1:0] == 2'h0)
		else $error("status reserved bits not zero");

	a_rx_third_drop: assert property (both_full && rx_msg_ok_i && !rel_now  // RULE22
		|=> $stable(s_r.cnt) && s_r.full == 2'h3)
		else $error("third message disturbed stored messages");

	a_rx_hold_set: assert property (both_full && acc_rx && !rx_msg_ok_i  // RULE10
		|=> s_r.rx_done)
		else $error("rx done cleared while second message buffered");

	a_rx_first_seen: assert property (  // RULE19
		s_r.full == 2'h0 && rx_msg_ok_i && rx_len_i <= 4'hB
		##1 !wr_i [*2] ##1 rd_i && addr_i == OFS_RX_COUNT_STATUS
		|=> rdata_o[3:0] == $past(rx_len_i, 4))
		else $error("received count not shown");

	a_rate_div1: assert property (s_r.rate == RATE_BUS_DIV1 && clk_run_o |=> base_tick_o)  // RULE23
		else $error("divide-by-one prescaler missed a pulse");

	a_clock_stop: assert property (cpu_wait_i && s_r.wait_clock_stop |-> !clk_run_o ##1 !base_tick_o)  // RULE6
		else $error("internal clocks ran during wait");

	// ----------------------------------------------------------------
	// transmit checks
	// ----------------------------------------------------------------
	a_tx_start_len: assert property (tx_start_o  // RULE14
		|-> tx_len_o >= 4'h1 && tx_len_o <= 4'hB)
		else $error("transmission started with invalid length");

	a_tx_reject_len: assert property (tx_reject_o  // RULE15
		|-> tx_len_o == 4'h0 || tx_len_o >= 4'hC)
		else $error("valid length rejected");

	a_tx_len_hold: assert property (!tx_end_i && !wr_tx |=> $stable(tx_len_o))  // RULE13
		else $error("tx count changed without write or end");

	a_tx_len_read: assert property (rd_i && addr_i == OFS_TX_LENGTH_CONTROL  // RULE13
		|=> rdata_o[7:4] == 4'h0 && rdata_o[3:0] == $past(tx_len_o))
		else $error("tx count read back wrong");

	a_tx_done_irq: assert property (tx_done_i && s_r.ie && !acc_ctl |=> irq_o)  // RULE9
		else $error("tx done raised no request");

	// ----------------------------------------------------------------
	// receive checks
	// ----------------------------------------------------------------
	sequence rx_release_s;
		wr_rx && s_r.full[s_r.head];
	endsequence

	a_rx_release: assert property (rx_release_s  // RULE20
		|=> rx_release_o && rx_sel_o != $past(rx_sel_o))
		else $error("release did not return the visible buffer");

	a_rx_expose: assert property (rx_release_s ##0 both_full  // RULE20
		|=> s_r.full[s_r.head] && s_r.rx_done)
		else $error("waiting message not exposed after release");

	a_rx_sel_hold: assert property (!rel_now |=> $stable(rx_sel_o))  // RULE22
		else $error("visible buffer changed without release");

	a_rx_done_set: assert property (rx_msg_ok_i && !both_full  // RULE19
		|=> s_r.rx_done && (irq_o || !s_r.ie))
		else $error("good reception not flagged");

	a_rx_clear_one: assert property (acc_rx && !both_full && !rx_msg_ok_i  // RULE10
		|=> !s_r.rx_done)
		else $error("rx done not cleared with one message");

	a_rx_count_max: assert property (rd_i && addr_i == OFS_RX_COUNT_STATUS  // RULE18
		|=> rdata_o <= 8'h0B)
		else $error("rx count above buffer size");

	// ----------------------------------------------------------------
	// interrupt and status checks
	// ----------------------------------------------------------------
	a_irq_flags: assert property (s_r.ie && (s_r.tx_done || s_r.rx_done) |-> irq_o)  // RULE11
		else $error("pending flag raised no request");

	a_irq_hold: assert property (  // RULE3
		s_r.ie && (s_r.tx_done || s_r.rx_done) && !acc_tx && !acc_rx && !acc_ctl
		|=> irq_o)
		else $error("request dropped before its source was cleared");

	a_status_nowrite: assert property (  // RULE7
		wr_i && acc_stat && !tx_done_i && !rx_msg_ok_i
		|=> $stable(s_r.tx_done) && $stable(s_r.rx_done))
		else $error("status write changed a flag");

	a_wake_flags: assert property (  // RULE8
		wakeup_i && !acc_tx && !acc_rx && !tx_done_i && !rx_msg_ok_i
		|=> $stable(s_r.tx_done) && $stable(s_r.rx_done))
		else $error("wake-up changed a status flag");

	a_ie_write: assert property (wr_i && acc_ctl  // RULE5
		|=> s_r.ie == $past(wdata_i[BIT_LINK_IRQ_ENABLE]))
		else $error("interrupt enable not written");

	// ----------------------------------------------------------------
	// rate checks
	// ----------------------------------------------------------------
	a_ctl_lock: assert property (wr_i && acc_ctl && s_r.locked  // RULE1
		|=> $stable(s_r.rate) && $stable(s_r.wait_clock_stop))
		else $error("rate or wait bit changed after first write");

	a_rate_osc: assert property (s_r.rate == RATE_OSC && clk_run_o  // RULE1
		|=> base_tick_o == $past(osc_tick_i))
		else $error("oscillator rate did not follow its tick");

	a_rate_div2: assert property (s_r.rate == RATE_BUS_DIV2 && base_tick_o  // RULE23
		|=> !base_tick_o)
		else $error("divide-by-two prescaler pulsed twice in a row");

endmodule : link_regs

// [dv/link_engine_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// protocol engine stand-in: finishes a transmission after a delay
// ----------------------------------------------------------------
module link_engine_model (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       tx_start_i,
	input  wire logic [3:0] delay_i,
	input  wire logic       rx_go_i,
	input  wire logic [3:0] rx_len_i,
	output logic            tx_done_o,
	output logic            tx_end_o,
	output logic            rx_ok_o,
	output logic      [3:0] rx_len_o
);
	logic [4:0] cnt_r;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r     <= 5'h00;
			tx_done_o <= 1'b0;
			rx_ok_o   <= 1'b0;
			rx_len_o  <= 4'h0;
		end else begin
			tx_done_o <= (cnt_r == 5'h01);
			if (tx_start_i)
				cnt_r <= {1'b0, delay_i} + 5'h02;
			else if (cnt_r != 5'h00)
				cnt_r <= cnt_r - 5'h01;
			rx_ok_o  <= rx_go_i;
			// length inverts every cycle outside the pulse instead of holding its value
			rx_len_o <= rx_go_i ? rx_len_i : ~rx_len_o;
		end
	end

	assign tx_end_o = tx_done_o;
endmodule : link_engine_model

// [dv/link_regs_bench.sv]
`timescale 1ns/1ps
module link_regs_bench
	import link_regs_pkg::*;
;
	logic       clk, rstn, wr, rd, osc, cw, wk, txd, txe, rxok, bt, cr, ts, tj, rr, rs, rf, irq;
	logic       rgo;
	logic [7:0] addr, wd, rdat, lf, d;
	logic [3:0] rxl, tl, dly, rgl, l, r2;
	int         fails, cmp_count, cyc, n, i, k;
	logic [3:0] corner [5] = '{4'h0, 4'h1, 4'hB, 4'hC, 4'hF};

	link_regs i_link_regs (.clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wd),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdat), .osc_tick_i(osc), .cpu_wait_i(cw),
		.wakeup_i(wk), .tx_done_i(txd), .tx_end_i(txe), .rx_msg_ok_i(rxok), .rx_len_i(rxl),
		.base_tick_o(bt), .clk_run_o(cr), .tx_start_o(ts), .tx_reject_o(tj), .tx_len_o(tl),
		.rx_release_o(rr), .rx_sel_o(rs), .rx_full_o(rf), .irq_o(irq));
	link_engine_model i_link_engine_model (.clk_i(clk), .rstn_i(rstn), .tx_start_i(ts),
		.delay_i(dly), .rx_go_i(rgo), .rx_len_i(rgl), .tx_done_o(txd), .tx_end_o(txe),
		.rx_ok_o(rxok), .rx_len_o(rxl));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	always #2 clk = ~clk;

	function automatic logic [7:0] nx(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : nx

	function automatic logic len_ok(input logic [3:0] v);
		return (v >= TX_LEN_MIN) && (v <= TX_LEN_MAX);
	endfunction : len_ok

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wd   <= v;
		wr   <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdat;
	endtask : rd_reg

	task automatic rx_msg(input logic [3:0] v);
		@(posedge clk);
		rgo <= 1'b1;
		rgl <= v;
		@(posedge clk);
		rgo <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : rx_msg

	always @(posedge clk) begin
		osc <= ~osc;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		{clk, rstn, wr, rd, osc, cw, wk, rgo} = '0;
		{addr, wd, dly, rgl} = '0;
		lf = 8'h27;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd_reg(OFS_TX_LENGTH_CONTROL, d); chk(d, 8'h00);
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h00);
		rd_reg(8'h20, d); chk(d, 8'h00);
		$display("test reset values done");
		wr_reg(OFS_LINK_CONTROL, 8'h23);
		wr_reg(OFS_LINK_CONTROL, 8'h10);
		rd_reg(OFS_LINK_CONTROL, d); chk(d, 8'h21);
		wr_reg(OFS_LINK_CONTROL, 8'h02);
		n = 0;
		repeat (16) begin @(posedge clk); #1; n += bt; end
		chk(8'(n), 8'h08);
		cw <= 1'b1;
		n = 0;
		repeat (8) begin @(posedge clk); #1; n += bt; end
		chk(8'(cr), 8'h00);
		chk(8'(n), 8'h00);
		cw <= 1'b0;
		wr_reg(OFS_LINK_STATUS, 8'hFF);
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h00);
		$display("test control and rate done");
		for (k = 0; k < 11; k++) begin
			lf  = nx(lf);
			l   = (k < 5) ? corner[k] : lf[3:0];
			dly <= lf[7:4];
			wr_reg(OFS_TX_LENGTH_CONTROL, {lf[7:4], l});
			chk(8'(tl), {4'h0, l});
			chk(8'(ts), 8'(len_ok(l)));
			chk(8'(tj), 8'(!len_ok(l)));
			rd_reg(OFS_TX_LENGTH_CONTROL, d); chk(d, {4'h0, l});
			if (len_ok(l)) begin
				i = 0;
				while (txe !== 1'b1 && i < 40) begin @(posedge clk); #1; i++; end
				@(posedge clk);
				#1;
				chk(8'(irq), 8'h01);
				rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h08);
				rd_reg(OFS_TX_LENGTH_CONTROL, d); chk(d, 8'h00);
				rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h00);
				chk(8'(irq), 8'h00);
			end
		end
		$display("test transmit lengths done");
		lf = nx(lf);
		r2 = 4'(lf % 11) + 4'h1;
		rx_msg(RX_CNT_MAX);
		rd_reg(OFS_RX_COUNT_STATUS, d); chk(d, 8'h0B);
		rx_msg(r2);
		chk(8'(rf), 8'h01);
		chk(8'(irq), 8'h01);
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h04);
		rx_msg(~r2);
		rd_reg(OFS_RX_COUNT_STATUS, d); chk(d, 8'h0B);
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h04);
		wr_reg(OFS_RX_COUNT_STATUS, lf);
		chk(8'(rr), 8'h01);
		chk(8'(rs), 8'h01);
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h04);
		rd_reg(OFS_RX_COUNT_STATUS, d); chk(d, {4'h0, r2});
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h00);
		chk(8'(irq), 8'h00);
		wr_reg(OFS_RX_COUNT_STATUS, 8'h00);
		$display("test receive buffers done");
		wr_reg(OFS_LINK_CONTROL, 8'h00);
		rx_msg(4'h2);
		chk(8'(irq), 8'h00);
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h04);
		@(posedge clk);
		wk <= 1'b1;
		@(posedge clk);
		wk <= 1'b0;
		@(posedge clk);
		#1;
		chk(8'(irq), 8'h01);
		rd_reg(OFS_LINK_STATUS, d); chk(d, 8'h04);
		rd_reg(OFS_RX_COUNT_STATUS, d); chk(d, 8'h02);
		chk(8'(irq), 8'h00);
		wr_reg(OFS_RX_COUNT_STATUS, 8'h00);
		$display("test wake and masking done");
		give_verdict();
	end
endmodule : link_regs_bench
